// ---- src/xcvr_dev.sv ----
// Device end: serial register slave, timing, bit-check and status logic.
// Overview of operation
// - Check-count code selects 0, 3, 6, 9 bits.
// - Receive low bound is min times scaled period.
// - Transmit half bit lasts min plus one periods.
// - Range code scales base period 8, 4, 2, 1.
// - Host picks range covering intended data rate.
// - Host avoids amplitude keying above 10 kbit/s.
// - Receive high bound is max minus one periods.
// - Status register readable over the serial link.
// - Wake, auxiliary or key events raise interrupt.
// - Status read clears flags and the interrupt.
// - Extension bit doubles the scaled timing period.
`timescale 1ns/1ps
module xcvr_dev (
  input wire logic pclk,
  input wire logic presetn,
  xcvr_link_if.dev link,
  input wire logic tx_mode,
  input wire logic demod_data,
  input wire logic [4:0] key_n,
  input wire logic pwr_on_pin,
  input wire logic vaux_ok_pin,
  input wire logic low_batt_pin,
  output logic bitcheck_ok,
  output logic tx_bitclk
);
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic sdi_s1;
    logic sdi_s2;
    logic dat_s1;
    logic dat_s2;
    logic dat_d;
    logic [4:0] key_s1;
    logic [4:0] key_s2;
    logic [4:0] key_d;
    logic pwr_s1;
    logic pwr_s2;
    logic pwr_d;
    logic aux_s1;
    logic aux_s2;
    logic aux_d;
    logic lb_s1;
    logic lb_s2;
    logic [4:0] bitcnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [7:0] cmd;
    logic sdo;
    logic [1:0] chk;
    logic [5:0] lmin;
    logic [1:0] range;
    logic [5:0] lmax;
    logic ext;
    logic pwr_f;
    logic lb_f;
    logic aux_f;
    logic [4:0] key_f;
    logic irq;
    logic [7:0] tcnt;
    logic [6:0] iv;
    logic [3:0] acc;
    logic seen;
    logic passed;
    logic [5:0] txc;
    logic txclk;
  } dev_state_s;

  dev_state_s st_reg;
  dev_state_s st_next;
  logic [7:0] period;
  logic tick;
  logic [3:0] need;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] rd_val;
  logic [7:0] wr_val;
  logic status_clr;
  logic in_window;

  always_comb begin
    st_next = st_reg;
    // Two-stage synchronisers for every input pin except presetn and tx_mode.
    st_next.cs_s1 = link.cs;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.sck_s1 = link.sck;
    st_next.sck_s2 = st_reg.sck_s1;
    st_next.sck_d = st_reg.sck_s2;
    st_next.sdi_s1 = link.sdi;
    st_next.sdi_s2 = st_reg.sdi_s1;
    st_next.dat_s1 = demod_data;
    st_next.dat_s2 = st_reg.dat_s1;
    st_next.dat_d = st_reg.dat_s2;
    st_next.key_s1 = key_n;
    st_next.key_s2 = st_reg.key_s1;
    st_next.key_d = st_reg.key_s2;
    st_next.pwr_s1 = pwr_on_pin;
    st_next.pwr_s2 = st_reg.pwr_s1;
    st_next.pwr_d = st_reg.pwr_s2;
    st_next.aux_s1 = vaux_ok_pin;
    st_next.aux_s2 = st_reg.aux_s1;
    st_next.aux_d = st_reg.aux_s2;
    st_next.lb_s1 = low_batt_pin;
    st_next.lb_s2 = st_reg.lb_s1;

    sck_rise = st_reg.cs_s2 && st_reg.sck_s2 && !st_reg.sck_d;
    sck_fall = st_reg.cs_s2 && !st_reg.sck_s2 && st_reg.sck_d;
    wr_val = {st_reg.shin[6:0], st_reg.sdi_s2};
    status_clr = 1'b0;

    // Register read view; the status word shows live key levels.
    if (wr_val[3:0] == xcvr_pkg::ADDR_EXT) begin
      rd_val = {7'h00, st_reg.ext};
    end else if (wr_val[3:0] == xcvr_pkg::ADDR_CHK_MIN) begin
      rd_val = {st_reg.chk, st_reg.lmin};
    end else if (wr_val[3:0] == xcvr_pkg::ADDR_RATE_MAX) begin
      rd_val = {st_reg.range, st_reg.lmax};
    end else if (wr_val[3:0] == xcvr_pkg::ADDR_STATUS) begin
      rd_val = {~st_reg.key_s2, st_reg.pwr_f, st_reg.lb_f,
                st_reg.aux_f};
    end else begin
      rd_val = 8'h00;
    end

    // Serial slave: sample on rising edge, shift out on falling edge.
    if (!st_reg.cs_s2) begin
      st_next.bitcnt = 5'h00;
      st_next.sdo = 1'b0;
    end else if (sck_rise && st_reg.bitcnt < xcvr_pkg::FRAME_BITS) begin
      st_next.shin = wr_val;
      st_next.bitcnt = st_reg.bitcnt + 5'h01;
      if (st_reg.bitcnt == xcvr_pkg::CMD_BITS - 5'h01) begin
        st_next.cmd = wr_val;
        st_next.shout = rd_val;
        status_clr = !wr_val[xcvr_pkg::CMD_WRITE_BIT] &&
                     wr_val[3:0] == xcvr_pkg::ADDR_STATUS;
      end
      if (st_reg.bitcnt == xcvr_pkg::FRAME_BITS - 5'h01 &&
          st_reg.cmd[xcvr_pkg::CMD_WRITE_BIT]) begin
        if (st_reg.cmd[3:0] == xcvr_pkg::ADDR_EXT) begin
          st_next.ext = wr_val[xcvr_pkg::EXT_BIT];
        end else if (st_reg.cmd[3:0] == xcvr_pkg::ADDR_CHK_MIN) begin
          st_next.chk = wr_val[7:xcvr_pkg::FIELD_HI_LSB];
          st_next.lmin = wr_val[5:0];
        end else if (st_reg.cmd[3:0] == xcvr_pkg::ADDR_RATE_MAX) begin
          st_next.range = wr_val[7:xcvr_pkg::FIELD_HI_LSB];
          st_next.lmax = wr_val[5:0];
        end
      end
    end else if (sck_fall && st_reg.bitcnt >= xcvr_pkg::CMD_BITS &&
                 !st_reg.cmd[xcvr_pkg::CMD_WRITE_BIT]) begin
      st_next.sdo = st_reg.shout[7];
      st_next.shout = {st_reg.shout[6:0], 1'b0};
    end

    // Status flags: a new event in the clearing cycle is kept.
    st_next.pwr_f = (st_reg.pwr_s2 && !st_reg.pwr_d) ||
                    (st_reg.pwr_f && !status_clr);
    st_next.aux_f = (st_reg.aux_s2 && !st_reg.aux_d) ||
                    (st_reg.aux_f && !status_clr);
    st_next.lb_f = st_reg.lb_s2 || (st_reg.lb_f && !status_clr);
    st_next.key_f = (st_reg.key_d & ~st_reg.key_s2) |
                    (status_clr ? 5'h00 : st_reg.key_f);
    st_next.irq = st_next.pwr_f || st_next.aux_f ||
                  (|st_next.key_f);

    // Scaled timing period in clock cycles.
    period = xcvr_pkg::DCLK_CYC << (xcvr_pkg::RANGE_SHIFT_MAX -
                                    st_reg.range);
    if (st_reg.ext) begin
      period = {period[6:0], 1'b0};
    end
    tick = st_reg.tcnt >= period - 8'h01;
    st_next.tcnt = tick ? 8'h00 : st_reg.tcnt + 8'h01;

    case (st_reg.chk)
      2'h0: need = xcvr_pkg::CHK_N0;
      2'h1: need = xcvr_pkg::CHK_N1;
      2'h2: need = xcvr_pkg::CHK_N2;
      default: need = xcvr_pkg::CHK_N3;
    endcase

    // Interval between data edges, counted in scaled periods.
    in_window = st_reg.iv >= {1'b0, st_reg.lmin} &&
                st_reg.iv <= {1'b0, st_reg.lmax} - 7'h01;
    if (tick && st_reg.iv != 7'h7f) begin
      st_next.iv = st_reg.iv + 7'h01;
    end
    if (tx_mode) begin
      st_next.acc = 4'h0;
      st_next.seen = 1'b0;
      st_next.passed = 1'b0;
      st_next.iv = 7'h00;
    end else if (need == 4'h0) begin
      st_next.passed = 1'b1;
    end else if (st_reg.dat_s2 != st_reg.dat_d && !st_reg.passed) begin
      st_next.iv = 7'h00;
      st_next.seen = 1'b1;
      if (st_reg.seen && in_window) begin
        st_next.acc = st_reg.acc + 4'h1;
        st_next.passed = st_reg.acc + 4'h1 >= need;
      end else begin
        st_next.acc = 4'h0;
      end
    end

    // Transmit bit clock toggles every lmin plus one scaled periods.
    if (!tx_mode) begin
      st_next.txc = 6'h00;
      st_next.txclk = 1'b0;
    end else if (tick) begin
      if (st_reg.txc >= st_reg.lmin) begin
        st_next.txc = 6'h00;
        st_next.txclk = !st_reg.txclk;
      end else begin
        st_next.txc = st_reg.txc + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.chk <= xcvr_pkg::CHK_RST;
      st_reg.lmin <= xcvr_pkg::MIN_RST;
      st_reg.range <= xcvr_pkg::RANGE_RST;
      st_reg.lmax <= xcvr_pkg::MAX_RST;
      st_reg.ext <= xcvr_pkg::EXT_RST;
      st_reg.key_s1 <= 5'h1f;
      st_reg.key_s2 <= 5'h1f;
      st_reg.key_d <= 5'h1f;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.sdo = st_reg.sdo;
  assign link.irq = st_reg.irq;
  assign bitcheck_ok = st_reg.passed;
  assign tx_bitclk = st_reg.txclk;
endmodule : xcvr_dev

// ---- shared/xcvr_pkg.sv ----
// Shared constants for the transceiver register link and its controller.
package xcvr_pkg;
  // Clock and link timing.
  localparam int CLK_NS = 25;
  localparam int SCK_PERIOD_NS = 200;
  localparam logic [7:0] SCK_HALF_CYC = 8'(SCK_PERIOD_NS / (2 * CLK_NS));
  localparam logic [7:0] DCLK_CYC = 8'h04;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // Device register addresses and fields.
  localparam logic [3:0] ADDR_EXT = 4'h3;
  localparam logic [3:0] ADDR_CHK_MIN = 4'h4;
  localparam logic [3:0] ADDR_RATE_MAX = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int CMD_WRITE_BIT = 7;
  localparam int FIELD_HI_LSB = 6;
  localparam int EXT_BIT = 0;
  localparam int ST_KEY_LSB = 3;
  localparam int ST_PWR_BIT = 2;
  localparam int ST_LOWBAT_BIT = 1;
  localparam int ST_AUX_BIT = 0;
  // Device reset values.
  localparam logic [1:0] CHK_RST = 2'h1;
  localparam logic [5:0] MIN_RST = 6'h10;
  localparam logic [1:0] RANGE_RST = 2'h2;
  localparam logic [5:0] MAX_RST = 6'h1c;
  localparam logic EXT_RST = 1'b0;
  // Bits verified per check-count code.
  localparam logic [3:0] CHK_N0 = 4'h0;
  localparam logic [3:0] CHK_N1 = 4'h3;
  localparam logic [3:0] CHK_N2 = 4'h6;
  localparam logic [3:0] CHK_N3 = 4'h9;
  localparam logic [1:0] RANGE_SHIFT_MAX = 2'h3;
  // Controller APB map.
  localparam logic [11:0] HOST_CMD = 12'h000;
  localparam logic [11:0] HOST_STAT = 12'h004;
  localparam logic [11:0] HOST_IRQ_STAT = 12'h008;
  localparam logic [11:0] HOST_IRQ_CLR = 12'h00c;
  localparam logic [11:0] HOST_IRQ_EN = 12'h010;
  localparam int HC_DATA_LSB = 0;
  localparam int HC_ADDR_LSB = 8;
  localparam int HC_WRITE_BIT = 12;
  localparam int HS_BUSY_BIT = 0;
  localparam int HS_RDATA_LSB = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_DEV_BIT = 1;
endpackage : xcvr_pkg

// ---- shared/xcvr_link_if.sv ----
// Four-wire serial link plus interrupt line between controller and device.
`timescale 1ns/1ps
interface xcvr_link_if;
  logic cs;
  logic sck;
  logic sdi;
  logic sdo;
  logic irq;
  modport dev (input cs, input sck, input sdi, output sdo, output irq);
  modport host (output cs, output sck, output sdi, input sdo, input irq);
endinterface : xcvr_link_if

// ---- src/xcvr_host.sv ----
// Controller end: APB registers driving frames on the four-wire link.
`timescale 1ns/1ps
module xcvr_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  xcvr_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_TAIL = 3'b100,
    H_GAP = 3'b101
  } host_st_e;

  typedef struct packed {
    host_st_e fsm;
    logic [7:0] cnt;
    logic [4:0] bit_i;
    logic cs;
    logic sck;
    logic sdi;
    logic [15:0] shtx;
    logic [7:0] shrx;
    logic [7:0] rdata;
    logic sdo_s1;
    logic sdo_s2;
    logic irq_s1;
    logic irq_s2;
    logic irq_d;
    logic [1:0] ist;
    logic [1:0] ien;
    logic irq_out;
  } host_state_s;

  host_state_s st_reg;
  host_state_s st_next;
  logic wr;
  logic half_done;
  logic mapped;
  logic [1:0] set_ev;
  logic [1:0] clr_ev;

  always_comb begin
    st_next = st_reg;
    st_next.sdo_s1 = link.sdo;
    st_next.sdo_s2 = st_reg.sdo_s1;
    st_next.irq_s1 = link.irq;
    st_next.irq_s2 = st_reg.irq_s1;
    st_next.irq_d = st_reg.irq_s2;
    wr = psel && penable && pwrite;
    half_done = st_reg.cnt >= xcvr_pkg::SCK_HALF_CYC - 8'h01;
    st_next.cnt = half_done ? 8'h00 : st_reg.cnt + 8'h01;
    set_ev = 2'h0;
    set_ev[xcvr_pkg::IRQ_DEV_BIT] = st_reg.irq_s2 && !st_reg.irq_d;
    clr_ev = 2'h0;

    case (st_reg.fsm)
      H_IDLE: begin
        st_next.cnt = 8'h00;
        if (wr && paddr == xcvr_pkg::HOST_CMD) begin
          st_next.shtx = {pwdata[xcvr_pkg::HC_WRITE_BIT], 3'h0,
                          pwdata[xcvr_pkg::HC_ADDR_LSB +: 4],
                          pwdata[xcvr_pkg::HC_DATA_LSB +: 8]};
          st_next.cs = 1'b1;
          st_next.bit_i = 5'h00;
          st_next.fsm = H_LEAD;
        end
      end
      H_LEAD: begin
        if (half_done) begin
          st_next.sdi = st_reg.shtx[15];
          st_next.fsm = H_LOW;
        end
      end
      H_LOW: begin
        if (half_done) begin
          st_next.sck = 1'b1;
          st_next.fsm = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          st_next.sck = 1'b0;
          st_next.shrx = {st_reg.shrx[6:0], st_reg.sdo_s2};
          st_next.shtx = {st_reg.shtx[14:0], 1'b0};
          st_next.sdi = st_reg.shtx[14];
          st_next.bit_i = st_reg.bit_i + 5'h01;
          if (st_reg.bit_i == xcvr_pkg::FRAME_BITS - 5'h01) begin
            st_next.fsm = H_TAIL;
          end else begin
            st_next.fsm = H_LOW;
          end
        end
      end
      H_TAIL: begin
        if (half_done) begin
          st_next.cs = 1'b0;
          st_next.sdi = 1'b0;
          st_next.rdata = st_reg.shrx;
          st_next.fsm = H_GAP;
        end
      end
      default: begin
        if (half_done) begin
          set_ev[xcvr_pkg::IRQ_DONE_BIT] = 1'b1;
          st_next.fsm = H_IDLE;
        end
      end
    endcase

    if (wr && paddr == xcvr_pkg::HOST_IRQ_CLR) begin
      clr_ev = pwdata[1:0];
    end
    if (wr && paddr == xcvr_pkg::HOST_IRQ_EN) begin
      st_next.ien = pwdata[1:0];
    end
    // A new event wins over a clear in the same cycle.
    st_next.ist = set_ev | (st_reg.ist & ~clr_ev);
    st_next.irq_out = |(st_next.ist & st_next.ien);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == xcvr_pkg::HOST_CMD) begin
      prdata = 32'h0000_0000;
    end else if (paddr == xcvr_pkg::HOST_STAT) begin
      prdata[xcvr_pkg::HS_BUSY_BIT] = st_reg.fsm != H_IDLE;
      prdata[xcvr_pkg::HS_RDATA_LSB +: 8] = st_reg.rdata;
    end else if (paddr == xcvr_pkg::HOST_IRQ_STAT) begin
      prdata[1:0] = st_reg.ist;
    end else if (paddr == xcvr_pkg::HOST_IRQ_CLR) begin
      prdata = 32'h0000_0000;
    end else if (paddr == xcvr_pkg::HOST_IRQ_EN) begin
      prdata[1:0] = st_reg.ien;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = st_reg.irq_out;
  assign link.cs = st_reg.cs;
  assign link.sck = st_reg.sck;
  assign link.sdi = st_reg.sdi;
endmodule : xcvr_host

// ---- tb/xcvr_link_asserts.sv ----
// Wire checks of the four-wire link between controller and device.
`timescale 1ns/1ps
module xcvr_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic irq
);
  logic sck_q;
  logic [4:0] rises;
  logic [7:0] cmd;
  logic stat_rd;
  // Counts clock rises in a frame and keeps the command byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      rises <= 5'h00;
      cmd <= 8'h00;
    end else begin
      sck_q <= sck;
      if (!cs) begin
        rises <= 5'h00;
      end else if (sck && !sck_q) begin
        rises <= rises + 5'h01;
        if (rises < 5'h08) begin
          cmd <= {cmd[6:0], sdi};
        end
      end
    end
  end
  assign stat_rd = !cmd[7] && cmd[3:0] == xcvr_pkg::ADDR_STATUS;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SCK_IDLE: assert property (!cs |-> !sck)
    else $error("serial clock active outside a frame");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase not four cycles");
  AST_SCK_LOW: assert property ($fell(sck) |-> !sck [*4])
    else $error("serial clock low phase too short");
  AST_FRAME_LEAD: assert property ($rose(cs) |-> !sck [*8])
    else $error("frame started without lead time");
  AST_SDI_HOLD: assert property ($rose(sck) |-> $stable(sdi) [*4])
    else $error("host data moved while clock high");
  AST_BIT_COUNT: assert property ($fell(cs) |-> rises == 5'h10)
    else $error("frame did not carry sixteen bits");
  AST_SDO_IDLE: assert property (!cs [*5] |-> !sdo)
    else $error("device data not low between frames");
  AST_SDO_CMD: assert property (cs && rises < 5'h08 |-> !sdo)
    else $error("device data not low during command");
  AST_IRQ_CLEAR: assert property (
    $rose(rises == 5'h08) && stat_rd |-> ##[1:8] !irq)
    else $error("status read did not drop the interrupt");
endmodule : xcvr_link_asserts

// ---- tb/bitcheck_rate_status_regs_tb.sv ----
// Self-checking bench: APB controller and device joined over the link.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  fails++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module bitcheck_rate_status_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic err;
  logic tx_mode = 1'b0;
  logic demod_data = 1'b0;
  logic [4:0] key_n = 5'h1f;
  logic pwr_on_pin = 1'b0;
  logic vaux_ok_pin = 1'b0;
  logic low_batt_pin = 1'b0;
  logic bitcheck_ok;
  logic tx_bitclk;
  logic [31:0] rd;
  logic [7:0] b;
  int fails = 0;
  int cmp_count = 0;
  int k;
  // Rows: range code, extension bit, min, max, expected pass.
  logic [7:0] tab [8][5] = '{
    '{8'h03, 8'h00, 8'h0a, 8'h1c, 8'h01}, '{8'h03, 8'h01, 8'h0a, 8'h1c, 8'h01},
    '{8'h02, 8'h00, 8'h0a, 8'h1c, 8'h01}, '{8'h02, 8'h01, 8'h0a, 8'h1c, 8'h00},
    '{8'h01, 8'h00, 8'h0a, 8'h1c, 8'h00}, '{8'h00, 8'h00, 8'h0a, 8'h1c, 8'h00},
    '{8'h03, 8'h00, 8'h0a, 8'h14, 8'h00}, '{8'h03, 8'h00, 8'h1e, 8'h3f, 8'h00}};
  xcvr_link_if link ();
  xcvr_host i_xcvr_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link));
  xcvr_dev i_xcvr_dev (.pclk(pclk), .presetn(presetn), .link(link),
    .tx_mode(tx_mode), .demod_data(demod_data), .key_n(key_n),
    .pwr_on_pin(pwr_on_pin), .vaux_ok_pin(vaux_ok_pin),
    .low_batt_pin(low_batt_pin), .bitcheck_ok(bitcheck_ok),
    .tx_bitclk(tx_bitclk));
  xcvr_link_asserts i_xcvr_link_asserts (.pclk(pclk), .presetn(presetn),
    .cs(link.cs), .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo),
    .irq(link.irq));
  always #12.5 pclk = ~pclk;
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task stuck(input string what);
    fails++;
    $display("mismatch %s exp done got timeout", what);
    end_of_test;
  endtask : stuck
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) stuck("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One device frame; a read leaves the returned byte in b.
  task dev(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, xcvr_pkg::HOST_CMD, {19'h0_0000, wr, a, d});
    n = 0;
    do begin
      apb(1'b0, xcvr_pkg::HOST_STAT, 32'h0000_0000);
      n++;
    end while (rd[xcvr_pkg::HS_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) stuck("frame");
    b = rd[15:8];
  endtask : dev
  task rst;
    presetn <= 1'b0;
    // The data synchroniser resets low, so the pin must rest low as well.
    demod_data <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  task edges(input int cnt, input int gap);
    repeat (cnt) begin
      repeat (gap) @(posedge pclk);
      demod_data <= ~demod_data;
    end
    repeat (12) @(posedge pclk);
  endtask : edges
  task toggle(output int cyc);
    logic v;
    v = tx_bitclk;
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (tx_bitclk === v && cyc < 500);
    if (cyc >= 500) stuck("tx_bitclk");
  endtask : toggle
  initial begin
    #2_000_000;
    stuck("run");
  end
  initial begin
    rst;
    dev(1'b0, xcvr_pkg::ADDR_CHK_MIN, 8'h00);
    `CHK("reg4", 8'h50, b)
    dev(1'b0, xcvr_pkg::ADDR_RATE_MAX, 8'h00);
    `CHK("reg5", 8'h9c, b)
    `CHK("ok_idle", 1'b0, bitcheck_ok)
    dev(1'b1, xcvr_pkg::ADDR_CHK_MIN, 8'hca);
    dev(1'b1, xcvr_pkg::ADDR_RATE_MAX, 8'h3f);
    dev(1'b0, xcvr_pkg::ADDR_CHK_MIN, 8'h00);
    `CHK("reg4_wr", 8'hca, b)
    dev(1'b0, xcvr_pkg::ADDR_RATE_MAX, 8'h00);
    `CHK("reg5_wr", 8'h3f, b)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h0000_0000, rd)
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      rst;
      dev(1'b1, xcvr_pkg::ADDR_RATE_MAX, 8'hdc);
      dev(1'b1, xcvr_pkg::ADDR_CHK_MIN, {c[1:0], 6'h0a});
      edges(3 * c, 80);
      `CHK("ok_early", c == 0, bitcheck_ok)
      edges(1, 80);
      `CHK("ok_pass", 1'b1, bitcheck_ok)
    end
    $display("test check count done");
    for (int i = 0; i < 8; i++) begin
      rst;
      dev(1'b1, xcvr_pkg::ADDR_EXT, {7'h00, tab[i][1][0]});
      dev(1'b1, xcvr_pkg::ADDR_CHK_MIN, {2'h1, tab[i][2][5:0]});
      dev(1'b1, xcvr_pkg::ADDR_RATE_MAX, {tab[i][0][1:0], tab[i][3][5:0]});
      edges(6, 96);
      `CHK("ok_scaled", tab[i][4][0], bitcheck_ok)
    end
    $display("test limits done");
    rst;
    // The host picks the top range for the fastest keyed rate it sends.
    dev(1'b1, xcvr_pkg::ADDR_RATE_MAX, 8'hdc);
    dev(1'b1, xcvr_pkg::ADDR_CHK_MIN, 8'h4a);
    tx_mode <= 1'b1;
    toggle(k);
    toggle(k);
    `CHK("tx_half", 11 * xcvr_pkg::DCLK_CYC, k)
    tx_mode <= 1'b0;
    $display("test transmit rate done");
    rst;
    apb(1'b1, xcvr_pkg::HOST_IRQ_EN, 32'h0000_0003);
    apb(1'b0, xcvr_pkg::HOST_IRQ_EN, 32'h0000_0000);
    `CHK("irq_en", 32'h0000_0003, rd)
    for (int i = 0; i < 7; i++) begin
      if (i < 5) key_n[i] <= 1'b0;
      else if (i == 5) pwr_on_pin <= 1'b1;
      else vaux_ok_pin <= 1'b1;
      for (k = 0; k < 50 && link.irq !== 1'b1; k++) @(posedge pclk);
      `CHK("dev_irq", 1'b1, link.irq)
      apb(1'b0, xcvr_pkg::HOST_IRQ_STAT, 32'h0000_0000);
      `CHK("irq_dev_bit", 1'b1, rd[xcvr_pkg::IRQ_DEV_BIT])
      `CHK("host_irq", 1'b1, irq)
      dev(1'b0, xcvr_pkg::ADDR_STATUS, 8'h00);
      `CHK("keys", i < 5 ? 8'h08 << i : 8'h00, b & 8'hf8)
      `CHK("dev_irq_clr", 1'b0, link.irq)
      dev(1'b0, xcvr_pkg::ADDR_STATUS, 8'h00);
      `CHK("flags_clr", 8'h00, b & 8'h07)
      key_n <= 5'h1f;
      // Clear the controller flags so each event must raise them anew.
      apb(1'b1, xcvr_pkg::HOST_IRQ_CLR, 32'h0000_0003);
    end
    pwr_on_pin <= 1'b0;
    vaux_ok_pin <= 1'b0;
    apb(1'b1, xcvr_pkg::HOST_IRQ_CLR, 32'h0000_0003);
    apb(1'b0, xcvr_pkg::HOST_IRQ_STAT, 32'h0000_0000);
    `CHK("irq_stat_clr", 32'h0000_0000, rd)
    `CHK("host_irq_clr", 1'b0, irq)
    apb(1'b1, xcvr_pkg::HOST_IRQ_EN, 32'h0000_0000);
    low_batt_pin <= 1'b1;
    dev(1'b0, xcvr_pkg::ADDR_STATUS, 8'h00);
    `CHK("low_batt", 8'h02, b & 8'h02)
    `CHK("low_batt_irq", 1'b0, link.irq)
    `CHK("irq_masked", 1'b0, irq)
    low_batt_pin <= 1'b0;
    dev(1'b0, xcvr_pkg::ADDR_STATUS, 8'h00);
    dev(1'b0, xcvr_pkg::ADDR_STATUS, 8'h00);
    `CHK("low_batt_clr", 8'h00, b & 8'h02)
    $display("test interrupts done");
    end_of_test;
  end
endmodule : bitcheck_rate_status_regs_tb
